// ===== src/sct_defs.svh
// constants of the scan clock and trigger block
`ifndef SCT_DEFS_SVH
`define SCT_DEFS_SVH

// ********************************
// register addresses
// ********************************
`define SCT_ADDR_CLK_SRC     16'h0FAE
`define SCT_ADDR_EXT_DIV     16'h0FB6
`define SCT_ADDR_TRIG_SEL    16'h0FB8
`define SCT_ADDR_OUT_TARGET  16'h0FC8
`define SCT_ADDR_OUT_ENABLE  16'h0FFA
`define SCT_ADDR_OUT_LOOPLEN 16'h10C2
`define SCT_ADDR_OUT_OCC     16'h10CC
`define SCT_ADDR_OUT_BUF     16'h1144
`define SCT_ADDR_ENABLE      16'h137E
`define SCT_ADDR_PERIOD      16'h1380
`define SCT_ADDR_PFU_MODE    16'h1382
`define SCT_ADDR_PFU_FALL    16'h1384
`define SCT_ADDR_STATUS      16'h1386

// ********************************
// codes and reset values
// ********************************
`define SCT_CLKSRC_EXTERNAL  32'h0000_0001
`define SCT_TRIG_NONE        32'h0000_0000
`define SCT_TRIG_PFU_BASE    32'h0000_07D0
`define SCT_EXT_DIV_RESET    32'h0000_0001
`define SCT_OUT_CHANNELS     4

// ********************************
// timing
// ********************************
`define SCT_CLK_PERIOD_NS    4
`define SCT_SCAN_PERIOD_NS   1000
`define SCT_SCAN_PERIOD_CYC \
  ((`SCT_SCAN_PERIOD_NS + `SCT_CLK_PERIOD_NS - 1) / `SCT_CLK_PERIOD_NS)

`endif

// ===== src/sct_pkg.sv
// types of the scan clock and trigger block
package sct_pkg;
  typedef enum logic [1:0] {
    sct_idle,
    sct_armed,
    sct_run
  } sct_state_t;

  typedef enum logic [1:0] {
    sct_pfu_off,
    sct_pfu_freq,
    sct_pfu_pwidth,
    sct_pfu_creset
  } sct_pfu_mode_t;
endpackage

// ===== src/sct_wave_mem.sv
// waveform buffer memory with registered read data
`timescale 1ns/1ns
module sct_wave_mem #(
  parameter int DEPTH = 32768,
  parameter int MAW   = $clog2(DEPTH)
) (
  input  wire logic            ref_clk_i,
  input  wire logic            arst_n_i,
  input  wire logic            ce_i,
  input  wire logic            we_i,
  input  wire logic [MAW-1:0]  waddr_i,
  input  wire logic [15:0]     wdata_i,
  input  wire logic            re_i,
  input  wire logic [MAW-1:0]  raddr_i,
  output logic      [15:0]     rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0]            rdata;
  } sct_mem_t;

  sct_mem_t s;
  sct_mem_t next_s;

  always_comb begin
    next_s = s;
    if (we_i) begin
      next_s.mem[waddr_i] = wdata_i;
    end
    if (re_i) begin
      next_s.rdata = s.mem[raddr_i];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
endmodule

// ===== src/sct_scan_trigger.sv
// scan clock, start trigger and waveform output sequencer
// What this block does
// RULE_01: scan rate from internal clock by default, external pulses if selected
// RULE_02: a clock source register picks the scan clock source
// RULE_03: external mode starts one scan per N pulses, N from divisor
// RULE_04: pulse counter emits one tick at divisor then restarts at zero
// RULE_05: trigger select zero starts scanning as soon as enabled
// RULE_06: codes 2000-2003, 2006, 2007 wait for that feature unit edge
// RULE_07: only frequency, pulse-width or conditional-reset units may trigger
// RULE_08: rising/falling selectable in freq and cond reset; pulse width any edge
// RULE_09: first sample one scan period after the trigger
// RULE_10: untriggered first scan one period after enable
// RULE_11: each output channel moves buffer values to its target
// RULE_12: at most four output channels
// RULE_13: buffer read linearly or looping
// RULE_14: each scan list occurrence consumes one value and writes the target
// RULE_15: output slot takes scan time like an input slot
// RULE_16: read position resets only on channel reset, not on stop
// RULE_17: restart continues waveform; host reconfigures to replay from start
`timescale 1ns/1ns
`include "sct_defs.svh"
module sct_scan_trigger import sct_pkg::*; #(
  parameter int          CH_DEPTH     = 8192,
  parameter logic [31:0] SCAN_PER_CYC = 32'(`SCT_SCAN_PERIOD_CYC)
) (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        external_scan_clock_pin_i,
  input  wire logic [7:0]  pin_feature_unit_pin_i,
  output logic             scan_tick_o,
  output logic             scanning_o,
  output logic      [3:0]  out_we_o,
  output logic      [15:0] out_data_o,
  output logic      [15:0] out_target_o
);
  localparam int NCH = `SCT_OUT_CHANNELS; // RULE_12
  localparam int AW  = $clog2(CH_DEPTH);
  localparam int MAW = AW + 2;
  localparam logic [AW:0] FULL = (AW+1)'(CH_DEPTH);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    sct_state_t                st;
    logic                      ext_s1;
    logic                      ext_s2;
    logic                      ext_prev;
    logic [7:0]                pfu_s1;
    logic [7:0]                pfu_s2;
    logic [7:0]                pfu_prev;
    logic                      clk_ext;
    logic [31:0]               ext_div;
    logic [31:0]               trig_sel;
    logic                      enable;
    logic [31:0]               period;
    logic [15:0]               pfu_mode;
    logic [7:0]                pfu_fall;
    logic [31:0]               tick_cnt;
    logic [NCH-1:0]            ch_en;
    logic [NCH-1:0][15:0]      target;
    logic [NCH-1:0][AW:0]      loop_len;
    logic [NCH-1:0][AW:0]      rd_ptr;
    logic [NCH-1:0][AW:0]      wr_ptr;
    logic [NCH-1:0][1:0]       occ;
    logic                      seq_act;
    logic [1:0]                seq_ch;
    logic [1:0]                seq_cnt;
    logic                      pend;
    logic [1:0]                pend_ch;
    logic                      scan_tick;
    logic                      scanning;
    logic [3:0]                out_we;
    logic [15:0]               out_data;
    logic [15:0]               out_target;
    logic [31:0]               rdata;
    logic                      rvalid;
  } sct_regs_t;
  sct_regs_t      s;
  sct_regs_t      next_s;
  logic           mem_we;
  logic [MAW-1:0] mem_waddr;
  logic [15:0]    mem_wdata;
  logic           mem_re;
  logic [MAW-1:0] mem_raddr;
  logic [15:0]    mem_rdata;
  logic [7:0]     pfu_edge;
  logic           ext_rise;
  logic [3:0]     trig;
  logic [2:0]     cd_tg;
  logic [2:0]     cd_en;
  logic [2:0]     cd_lp;
  logic [2:0]     cd_oc;
  logic [2:0]     cd_bf;
  logic [1:0]     c;
  logic [AW:0]    rd_nxt;
  // ********************************
  // decoders
  // ********************************
  function automatic logic [2:0] ch_decode(input logic [15:0] a,
                                           input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    ch_decode = {d < 16'h0004, d[1:0]};
  endfunction
  function automatic logic [3:0] trig_decode(input logic [31:0] sel);
    logic [31:0] d;
    d = sel - `SCT_TRIG_PFU_BASE;
    trig_decode = {(d < 32'h4) || (d == 32'h6) || (d == 32'h7), d[2:0]};
  endfunction
  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_s    = s;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_re    = 1'b0;
    mem_raddr = '0;
    c         = 2'h0;
    rd_nxt    = '0;
    cd_tg     = ch_decode(reg_addr_i, `SCT_ADDR_OUT_TARGET);
    cd_en     = ch_decode(reg_addr_i, `SCT_ADDR_OUT_ENABLE);
    cd_lp     = ch_decode(reg_addr_i, `SCT_ADDR_OUT_LOOPLEN);
    cd_oc     = ch_decode(reg_addr_i, `SCT_ADDR_OUT_OCC);
    cd_bf     = ch_decode(reg_addr_i, `SCT_ADDR_OUT_BUF);
    trig      = trig_decode(s.trig_sel);
    next_s.scan_tick = 1'b0;
    next_s.out_we    = '0;
    next_s.rvalid    = 1'b0;
    next_s.pend      = 1'b0;
    // pin synchronisers and edge detection
    next_s.ext_s1   = external_scan_clock_pin_i;
    next_s.ext_s2   = s.ext_s1;
    next_s.ext_prev = s.ext_s2;
    next_s.pfu_s1   = pin_feature_unit_pin_i;
    next_s.pfu_s2   = s.pfu_s1;
    next_s.pfu_prev = s.pfu_s2;
    ext_rise = s.ext_s2 & ~s.ext_prev;
    for (int i = 0; i < 8; i++) begin
      case (sct_pfu_mode_t'(s.pfu_mode[2*i +: 2]))
        sct_pfu_freq, sct_pfu_creset: begin
          pfu_edge[i] = s.pfu_fall[i] ? (s.pfu_prev[i] & ~s.pfu_s2[i])
                                      : (~s.pfu_prev[i] & s.pfu_s2[i]); // RULE_08
        end
        sct_pfu_pwidth: pfu_edge[i] = s.pfu_prev[i] ^ s.pfu_s2[i]; // RULE_08
        default:        pfu_edge[i] = 1'b0; // RULE_07
      endcase
    end
    // scan timing
    case (s.st)
      sct_idle: begin
        if (s.enable) begin
          next_s.tick_cnt = '0; // RULE_10
          if (s.trig_sel == `SCT_TRIG_NONE) begin
            next_s.st = sct_run; // RULE_05
          end else begin
            next_s.st = sct_armed; // RULE_06
          end
        end
      end
      sct_armed: begin
        if (!s.enable) begin
          next_s.st = sct_idle;
        end else if (trig[3] && pfu_edge[trig[2:0]]) begin
          next_s.st       = sct_run; // RULE_06
          next_s.tick_cnt = '0; // RULE_09
        end
      end
      sct_run: begin
        if (!s.enable) begin
          next_s.st      = sct_idle; // RULE_16
          next_s.seq_act = 1'b0;
        end else if (s.clk_ext) begin // RULE_01
          if (ext_rise) begin
            if (s.tick_cnt + 32'h1 >= s.ext_div) begin // RULE_03
              next_s.tick_cnt  = '0; // RULE_04
              next_s.scan_tick = 1'b1;
            end else begin
              next_s.tick_cnt = s.tick_cnt + 32'h1; // RULE_04
            end
          end
        end else if (s.tick_cnt + 32'h1 >= s.period) begin // RULE_01
          next_s.tick_cnt  = '0;
          next_s.scan_tick = 1'b1;
        end else begin
          next_s.tick_cnt = s.tick_cnt + 32'h1;
        end
      end
      default: next_s.st = sct_idle;
    endcase
    next_s.scanning = (next_s.st == sct_run);
    // output slot sequencer, one cycle per slot
    if (s.seq_act) begin
      c = s.seq_ch;
      if (s.seq_cnt < s.occ[c] && s.ch_en[c]) begin // RULE_15
        next_s.seq_cnt = s.seq_cnt + 2'h1;
        if (s.loop_len[c] != '0) begin // RULE_13
          rd_nxt = (s.rd_ptr[c] + 1'b1 >= s.loop_len[c]) ? '0
                                                         : s.rd_ptr[c] + 1'b1;
          mem_re = 1'b1;
        end else if (s.rd_ptr[c] != s.wr_ptr[c]) begin // RULE_13
          rd_nxt = s.rd_ptr[c] + 1'b1;
          mem_re = 1'b1;
        end
        if (mem_re) begin
          mem_raddr        = {c, s.rd_ptr[c][AW-1:0]}; // RULE_14
          next_s.rd_ptr[c] = rd_nxt;
          next_s.pend      = 1'b1;
          next_s.pend_ch   = c;
        end
      end else begin
        next_s.seq_cnt = 2'h0;
        if (c == 2'h3) begin
          next_s.seq_act = 1'b0;
        end else begin
          next_s.seq_ch = c + 2'h1;
        end
      end
    end
    if (next_s.scan_tick) begin
      next_s.seq_act = 1'b1; // RULE_14
      next_s.seq_ch  = 2'h0;
      next_s.seq_cnt = 2'h0;
    end
    if (s.pend) begin
      next_s.out_we[s.pend_ch] = 1'b1; // RULE_11
      next_s.out_data          = mem_rdata;
      next_s.out_target        = s.target[s.pend_ch];
    end
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SCT_ADDR_CLK_SRC: begin
          next_s.clk_ext = (reg_wdata_i == `SCT_CLKSRC_EXTERNAL); // RULE_02
        end
        `SCT_ADDR_EXT_DIV:  next_s.ext_div  = reg_wdata_i; // RULE_03
        `SCT_ADDR_TRIG_SEL: next_s.trig_sel = reg_wdata_i; // RULE_05
        `SCT_ADDR_ENABLE:   next_s.enable   = reg_wdata_i[0];
        `SCT_ADDR_PERIOD:   next_s.period   = reg_wdata_i;
        `SCT_ADDR_PFU_MODE: next_s.pfu_mode = reg_wdata_i[15:0];
        `SCT_ADDR_PFU_FALL: next_s.pfu_fall = reg_wdata_i[7:0];
        default: begin
          if (cd_tg[2]) begin
            next_s.target[cd_tg[1:0]] = reg_wdata_i[15:0];
          end
          if (cd_en[2]) begin
            next_s.ch_en[cd_en[1:0]]  = reg_wdata_i[0];
            next_s.rd_ptr[cd_en[1:0]] = '0; // RULE_16
            next_s.wr_ptr[cd_en[1:0]] = '0; // RULE_17
          end
          if (cd_lp[2]) begin
            next_s.loop_len[cd_lp[1:0]] = reg_wdata_i[AW:0];
          end
          if (cd_oc[2]) begin
            next_s.occ[cd_oc[1:0]] = reg_wdata_i[1:0];
          end
          if (cd_bf[2] && s.wr_ptr[cd_bf[1:0]] < FULL) begin
            mem_we    = 1'b1;
            mem_waddr = {cd_bf[1:0], s.wr_ptr[cd_bf[1:0]][AW-1:0]};
            mem_wdata = reg_wdata_i[15:0];
            next_s.wr_ptr[cd_bf[1:0]] = s.wr_ptr[cd_bf[1:0]] + 1'b1;
          end
        end
      endcase
    end
    // register reads
    if (reg_rd_i) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = '0;
      case (reg_addr_i)
        `SCT_ADDR_CLK_SRC:  next_s.rdata = {31'h0, s.clk_ext};
        `SCT_ADDR_EXT_DIV:  next_s.rdata = s.ext_div;
        `SCT_ADDR_TRIG_SEL: next_s.rdata = s.trig_sel;
        `SCT_ADDR_ENABLE:   next_s.rdata = {31'h0, s.enable};
        `SCT_ADDR_PERIOD:   next_s.rdata = s.period;
        `SCT_ADDR_PFU_MODE: next_s.rdata = {16'h0, s.pfu_mode};
        `SCT_ADDR_PFU_FALL: next_s.rdata = {24'h0, s.pfu_fall};
        `SCT_ADDR_STATUS: begin
          next_s.rdata = {25'h0, s.seq_act, s.ch_en, s.st == sct_armed,
                          s.st == sct_run};
        end
        default: begin
          if (cd_tg[2]) begin
            next_s.rdata = {16'h0, s.target[cd_tg[1:0]]};
          end else if (cd_en[2]) begin
            next_s.rdata = {31'h0, s.ch_en[cd_en[1:0]]};
          end else if (cd_lp[2]) begin
            next_s.rdata = 32'(s.loop_len[cd_lp[1:0]]);
          end else if (cd_oc[2]) begin
            next_s.rdata = {30'h0, s.occ[cd_oc[1:0]]};
          end
        end
      endcase
    end
  end
  // ********************************
  // registers
  // ********************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s         <= '0;
      s.ext_div <= `SCT_EXT_DIV_RESET;
      s.period  <= SCAN_PER_CYC;
    end else if (ce_i) begin
      s <= next_s;
    end
  end
  sct_wave_mem #(
    .DEPTH (NCH * CH_DEPTH),
    .MAW   (MAW)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .ce_i      (ce_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .re_i      (mem_re),
    .raddr_i   (mem_raddr),
    .rdata_o   (mem_rdata)
  );
  assign reg_rdata_o  = s.rdata;
  assign reg_rvalid_o = s.rvalid;
  assign scan_tick_o  = s.scan_tick;
  assign scanning_o   = s.scanning;
  assign out_we_o     = s.out_we;
  assign out_data_o   = s.out_data;
  assign out_target_o = s.out_target;
endmodule

// ===== sim/sct_assertions.sv
// checker of the scan clock and trigger block
`timescale 1ns/1ns
module sct_chk #(
  parameter int          CH_DEPTH     = 16,
  parameter logic [31:0] SCAN_PER_CYC = 32'h0000_0008
) (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        ce_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        scan_tick_o,
  input wire logic        scanning_o,
  input wire logic [3:0]  out_we_o,
  input wire logic [15:0] out_data_o,
  input wire logic [15:0] out_target_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****
  // assertions
  // ****
  rd_answer_a: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
    else $error("read not answered");
  rd_source_a: assert property (
    reg_rvalid_o |-> $past(reg_rd_i && ce_i))
    else $error("read answer without read");
  tick_run_a: assert property (scan_tick_o |-> scanning_o)
    else $error("scan tick outside run");
  tick_gap_a: assert property (
    scan_tick_o |=> !scan_tick_o [*3])
    else $error("scan ticks too close");
  first_wait_a: assert property (
    $rose(scanning_o) |-> !scan_tick_o [*8])
    else $error("first scan before one period");
  we_onehot_a: assert property ($onehot0(out_we_o))
    else $error("two channels written at once");
  stop_quiet_a: assert property (
    !scanning_o [*5] |-> out_we_o == 4'h0)
    else $error("output write while stopped");
  data_hold_a: assert property (
    out_we_o == 4'h0 |-> $stable(out_data_o) && $stable(out_target_o))
    else $error("output value moved without write");
endmodule

bind sct_scan_trigger sct_chk #(.CH_DEPTH(CH_DEPTH),
  .SCAN_PER_CYC(SCAN_PER_CYC)) u_chk (.ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i), .ce_i(ce_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .scan_tick_o(scan_tick_o), .scanning_o(scanning_o),
  .out_we_o(out_we_o), .out_data_o(out_data_o),
  .out_target_o(out_target_o));

// ===== sim/sct_pulse_model.sv
// model of the external scan clock and feature unit pins
`timescale 1ns/1ns
module sct_pulse_model (
  input  wire logic ref_clk_i,
  output logic      ext_clk_o,
  output logic [7:0] pin_o
);
  initial begin
    ext_clk_o = 1'b0;
    pin_o     = 8'h00;
  end
  // pulses wider than the pin synchroniser
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge ref_clk_i) ext_clk_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      ext_clk_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge ref_clk_i) pin_o[idx] <= lvl;
  endtask
endmodule

// ===== sim/stream_scan_clock_trigger_test.sv
// self-checking bench of the scan clock and trigger block
`timescale 1ns/1ns
`include "sct_defs.svh"
module stream_scan_clock_trigger_test;
  localparam logic [31:0] P = 32'h0000_0008;
  logic        ref_clk_i   = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic        ce_i        = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [15:0] reg_addr_i  = 16'h0000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic        reg_rvalid_o, ext_clk, scan_tick_o, scanning_o;
  logic [7:0]  pins;
  logic [3:0]  out_we_o;
  logic [15:0] out_data_o, out_target_o;
  logic [31:0] q[2][$];
  int          error_cnt = 0;
  int          compares  = 0;
  int          n, ticks;
  int          ids[6] = '{0, 1, 2, 3, 6, 7};

  initial forever #2 ref_clk_i = ~ref_clk_i;

  sct_pulse_model pm (.ref_clk_i(ref_clk_i), .ext_clk_o(ext_clk),
    .pin_o(pins));
  sct_scan_trigger #(.CH_DEPTH(16), .SCAN_PER_CYC(P)) dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .external_scan_clock_pin_i(ext_clk),
    .pin_feature_unit_pin_i(pins), .scan_tick_o(scan_tick_o),
    .scanning_o(scanning_o), .out_we_o(out_we_o),
    .out_data_o(out_data_o), .out_target_o(out_target_o));

  always @(posedge ref_clk_i) begin
    if (scan_tick_o === 1'b1) ticks++;
    for (int c = 0; c < 2; c++)
      if (out_we_o[c] === 1'b1) q[c].push_back({out_target_o, out_data_o});
  end

  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    check({31'h0, reg_rvalid_o}, 32'h1);
    check(reg_rdata_o, e);
  endtask
  task automatic gap(input logic [31:0] exp);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (scan_tick_o !== 1'b1 && n < 300);
    check(n, exp);
  endtask
  task automatic trig(input int idx, input logic [31:0] mode, fall,
                      input logic lvl, input logic go);
    wr(`SCT_ADDR_PFU_MODE, mode);
    wr(`SCT_ADDR_PFU_FALL, fall);
    wr(`SCT_ADDR_TRIG_SEL, `SCT_TRIG_PFU_BASE + 32'(idx));
    pm.set_pin(idx, lvl);
    repeat (4) @(posedge ref_clk_i);
    wr(`SCT_ADDR_ENABLE, 32'h1);
    repeat (12) @(posedge ref_clk_i);
    check({31'h0, scanning_o}, 32'h0);
    pm.set_pin(idx, !lvl);
    n = 0;
    while (scanning_o !== 1'b1 && n < 12) begin
      @(posedge ref_clk_i);
      n++;
    end
    check({31'h0, scanning_o}, {31'h0, go});
    if (go) gap(P);
    wr(`SCT_ADDR_ENABLE, 32'h0);
  endtask
  task automatic run(input int k);
    ticks = 0;
    wr(`SCT_ADDR_ENABLE, 32'h1);
    n = 0;
    while (ticks < k && n < 1000) begin
      @(posedge ref_clk_i);
      n++;
    end
    repeat (8) @(posedge ref_clk_i);
    wr(`SCT_ADDR_ENABLE, 32'h0);
    check(ticks, k);
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd_chk(`SCT_ADDR_CLK_SRC, 32'h0);
    rd_chk(`SCT_ADDR_EXT_DIV, `SCT_EXT_DIV_RESET);
    rd_chk(`SCT_ADDR_TRIG_SEL, `SCT_TRIG_NONE);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    wr(`SCT_ADDR_EXT_DIV, 32'h5);
    @(posedge ref_clk_i) ce_i <= 1'b1;
    rd_chk(`SCT_ADDR_EXT_DIV, `SCT_EXT_DIV_RESET);
    rd_chk(16'h0FFE, 32'h0);
    wr(`SCT_ADDR_CLK_SRC, `SCT_CLKSRC_EXTERNAL);
    rd_chk(`SCT_ADDR_CLK_SRC, `SCT_CLKSRC_EXTERNAL);
    wr(`SCT_ADDR_CLK_SRC, 32'h0);
    $display("test 1 done");
    wr(`SCT_ADDR_ENABLE, 32'h1);
    gap(P + 32'h2);
    gap(P);
    wr(`SCT_ADDR_ENABLE, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    check({31'h0, scanning_o}, 32'h0);
    $display("test 2 done");
    wr(`SCT_ADDR_CLK_SRC, `SCT_CLKSRC_EXTERNAL);
    wr(`SCT_ADDR_EXT_DIV, 32'h3);
    wr(`SCT_ADDR_ENABLE, 32'h1);
    ticks = 0;
    pm.pulses(7);
    repeat (8) @(posedge ref_clk_i);
    check(ticks, 32'h2);
    pm.pulses(2);
    repeat (8) @(posedge ref_clk_i);
    check(ticks, 32'h3);
    wr(`SCT_ADDR_ENABLE, 32'h0);
    wr(`SCT_ADDR_CLK_SRC, 32'h0);
    $display("test 3 done");
    for (int i = 0; i < 6; i++)
      trig(ids[i], 32'h0000_5555, 32'h0, 1'b0, 1'b1);
    trig(0, 32'h0000_5554, 32'h0, 1'b0, 1'b0);
    trig(0, 32'h0000_5556, 32'h0, 1'b1, 1'b1);
    trig(0, 32'h0000_5557, 32'h1, 1'b1, 1'b1);
    trig(0, 32'h0000_5555, 32'h1, 1'b0, 1'b0);
    wr(`SCT_ADDR_TRIG_SEL, `SCT_TRIG_NONE);
    $display("test 4 done");
    wr(`SCT_ADDR_PERIOD, 32'h0000_0020);
    for (int c = 0; c < 2; c++) begin
      wr(`SCT_ADDR_OUT_TARGET + 16'(c), 32'h0BB8 + 32'(2 * c));
      wr(`SCT_ADDR_OUT_OCC + 16'(c), 32'h1);
      wr(`SCT_ADDR_OUT_ENABLE + 16'(c), 32'h1);
    end
    rd_chk(`SCT_ADDR_STATUS, 32'h0000_000C);
    wr(`SCT_ADDR_OUT_LOOPLEN + 16'h1, 32'h2);
    for (int i = 0; i < 3; i++)
      wr(`SCT_ADDR_OUT_BUF, 32'h0A01 + 32'(i));
    for (int i = 0; i < 2; i++)
      wr(`SCT_ADDR_OUT_BUF + 16'h1, 32'h0B01 + 32'(i));
    run(4);
    check(q[0].size(), 32'h3);
    for (int i = 0; i < 3; i++)
      check(q[0][i], 32'h0BB8_0A01 + 32'(i));
    check(q[1].size(), 32'h4);
    for (int i = 0; i < 4; i++)
      check(q[1][i], 32'h0BBA_0B01 + 32'(i % 2));
    $display("test 5 done");
    q[0].delete();
    wr(`SCT_ADDR_OUT_BUF, 32'h0A04);
    run(2);
    check(q[0].size(), 32'h1);
    check(q[0][0], 32'h0BB8_0A04);
    q[0].delete();
    wr(`SCT_ADDR_OUT_ENABLE, 32'h1);
    wr(`SCT_ADDR_OUT_BUF, 32'h0A06);
    run(1);
    check(q[0][0], 32'h0BB8_0A06);
    $display("test 6 done");
    report_and_stop;
  end
endmodule
